//--- oss_defs.svh
`ifndef OSS_DEFS_SVH
`define OSS_DEFS_SVH
// word length of command and status words
`define OSS_WORD_BITS 8
// reset value of latched command: all channels off
`define OSS_CMD_RST 8'h00
// index of channel five and six bits in the command word
`define OSS_CH5_BIT 4
`define OSS_CH6_BIT 5
`endif

//--- oss_pkg.sv
package oss_pkg;
  // pin group from the host, raw and unsynchronised
  typedef struct packed {
    logic csN;
    logic sclk;
    logic sdi;
  } oss_link_s;
  // serial output pin as two signals: data and its output enable
  typedef struct packed {
    logic dout;
    logic doutOe;
  } oss_dout_s;
  typedef logic [7:0] oss_word_t;
endpackage

//--- oss_serial_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "oss_defs.svh"
// Overview of operation
// - serial output tri-stated while chip select high
// - status bit one means faulted channel
// - first rising clock shows channel eight status
// - both words shift msb first, fifo order
// - gates, fault detect, report only when enabled
// - enabled channels return when enable rises
// - channels five, six OR direct inputs
// - supply monitor low holds reset, all off
// - command bit one on, zero off
// - chip select rise copies shift register out
// - status shifts out while command shifts in
// - data sampled on falling clock, select low
// - select fall loads fault status
// - clock and data ignored while select high
module oss_serial_ctrl
  import oss_pkg::*;
#(
  parameter int WORD_BITS = `OSS_WORD_BITS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic supplyLowN,
  input wire oss_link_s linkIn,
  input wire logic chargePumpEn,
  input wire logic direct_pwm_in_five,
  input wire logic direct_pwm_in_six,
  input wire logic [WORD_BITS-1:0] chanFault,
  output oss_dout_s doutPin,
  output logic [WORD_BITS-1:0] gateDrive,
  output logic faultSenseEn
);
  // two-stage synchronisers for the link pins, the enable and both direct inputs
  // bit order in both stages: select, clock, data, enable, pwm five, pwm six
  logic [5:0] syncA_r, syncA_nxt; // first stage, read only by second stage
  logic [5:0] syncB_r, syncB_nxt; // second stage, the only stage logic may read
  // synced copies of the outside levels, taken from the second stage
  logic csN_q, sclk_q, sdi_q, en_q, pwm5_q, pwm6_q;
  logic csPrev_r, sclkPrev_r; // previous synced levels for edge finding
  logic [WORD_BITS-1:0] shift_r, shift_nxt; // command in, status out
  logic [WORD_BITS-1:0] cmd_r, cmd_nxt; // latched command word
  logic dout_r, dout_nxt; // serial output bit
  logic doutOe_r, doutOe_nxt;
  // one-cycle strobes found from the synced levels
  logic csFall, csRise, sclkRise, sclkFall;
  // combined reset: external reset or logic supply below threshold
  logic devRst;

  // supply monitor low acts as a held reset on top of rst
  // the monitor is a level, so the device stays in reset as long as it is low
  assign devRst = rst | ~supplyLowN;

  // synchroniser next values: the first stage takes the raw pins,
  // the second stage takes the first stage and nothing else
  always_comb begin
    syncA_nxt = {linkIn.csN, linkIn.sclk, linkIn.sdi, chargePumpEn,
                 direct_pwm_in_five, direct_pwm_in_six};
    syncB_nxt = syncA_r;
  end

  // synchroniser registers; only the second stage feeds logic
  // reset value: select high, clock low, enable and direct inputs low,
  // so no channel can be driven while the device sits in reset
  always_ff @(posedge clk_sys or posedge devRst) begin
    if (devRst) begin
      syncA_r <= 6'h20;
      syncB_r <= 6'h20;
    end else if (clkEn) begin
      syncA_r <= syncA_nxt;
      syncB_r <= syncB_nxt;
    end
  end
  // clock resets low to match its parked level, so no false edge follows reset
  assign {csN_q, sclk_q, sdi_q, en_q, pwm5_q, pwm6_q} = syncB_r;

  // edge detection on synced select and serial clock
  // the previous levels are registered below with the rest of the state
  // clock edges are masked while select is high, so idle clock noise
  // cannot disturb the shifter or the output bit
  // limitation: clock edges closer than one system cycle can be lost
  assign csFall = csPrev_r & ~csN_q;
  assign csRise = ~csPrev_r & csN_q;
  assign sclkRise = ~sclkPrev_r & sclk_q & ~csN_q;
  assign sclkFall = sclkPrev_r & ~sclk_q & ~csN_q;

  // next state of shifter, output bit and command latch
  // select fall has priority: the status snapshot must not be lost to a
  // clock edge that the host started too early
  // select rise copies the shifter without shifting it again
  always_comb begin
    shift_nxt = shift_r;
    dout_nxt = dout_r;
    cmd_nxt = cmd_r;
    doutOe_nxt = ~csN_q;
    if (csFall) begin
      // snapshot faults; zero while enable is low since no detection runs
      shift_nxt = en_q ? chanFault : '0;
    end else if (sclkRise) begin
      // present msb: channel eight first, then each lower one
      dout_nxt = shift_r[WORD_BITS-1];
    end else if (sclkFall) begin
      // shift left, sample input into lsb; msb leaves after eight clocks
      shift_nxt = {shift_r[WORD_BITS-2:0], sdi_q};
    end
    if (csRise) begin
      cmd_nxt = shift_r;
    end
  end

  // state registers
  // reset values are constants only; the command resets to all channels off
  // clkEn low freezes every register here, including the edge history
  always_ff @(posedge clk_sys or posedge devRst) begin
    if (devRst) begin
      csPrev_r <= 1'b1;
      sclkPrev_r <= 1'b0;
      shift_r <= '0;
      cmd_r <= `OSS_CMD_RST;
      dout_r <= 1'b0;
      doutOe_r <= 1'b0;
    end else if (clkEn) begin
      csPrev_r <= csN_q;
      sclkPrev_r <= sclk_q;
      shift_r <= shift_nxt;
      cmd_r <= cmd_nxt;
      dout_r <= dout_nxt;
      doutOe_r <= doutOe_nxt;
    end
  end

  // drive word: command kept while enable low, so outputs return on its own
  // direct inputs are ORed in after the latch, so a pwm pulse needs no frame
  // trade-off: the drive word is combinational from registers and synced
  // inputs, which saves a cycle of latency on the pwm path
  always_comb begin
    gateDrive = cmd_r;
    gateDrive[`OSS_CH5_BIT] = cmd_r[`OSS_CH5_BIT] | pwm5_q;
    gateDrive[`OSS_CH6_BIT] = cmd_r[`OSS_CH6_BIT] | pwm6_q;
    if (!en_q) begin
      gateDrive = '0;
    end
  end
  // fault sensing follows the synced enable level
  assign faultSenseEn = en_q;

  // serial output pin: data and enable both come from flip-flops
  assign doutPin.dout = dout_r;
  assign doutPin.doutOe = doutOe_r;

  // checks on the control path; each is disabled while the device is in reset
  // except the two supply checks, which must hold exactly then
  AST_TRISTATE: assert property (@(posedge clk_sys) disable iff (devRst)
    csN_q |=> !doutOe_r) else $error("serial output driven while select high");
  AST_LATCH: assert property (@(posedge clk_sys) disable iff (devRst)
    (clkEn && csRise) |=> cmd_r == $past(shift_r)) else $error("command not latched");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (devRst)
    (clkEn && csN_q && !csRise) |=> $stable(cmd_r)) else $error("command changed idle");
  AST_ENOFF: assert property (@(posedge clk_sys) disable iff (devRst)
    !en_q |-> gateDrive == '0) else $error("drive while disabled");
  AST_RETURN: assert property (@(posedge clk_sys) disable iff (devRst)
    (en_q && !pwm5_q && !pwm6_q) |-> gateDrive == cmd_r) else $error("drive mismatch");
  AST_PWM: assert property (@(posedge clk_sys) disable iff (devRst)
    (en_q && pwm5_q) |-> gateDrive[`OSS_CH5_BIT]) else $error("direct input ignored");
  AST_LOAD: assert property (@(posedge clk_sys) disable iff (devRst)
    (clkEn && csFall && en_q) |=> shift_r == $past(chanFault)) else $error("status not loaded");
  AST_SHIFT: assert property (@(posedge clk_sys) disable iff (devRst)
    (clkEn && sclkFall && !csFall) |=> shift_r[0] == $past(sdi_q)) else $error("bad shift");
  AST_MSB: assert property (@(posedge clk_sys) disable iff (devRst)
    (clkEn && sclkRise) |=> dout_r == $past(shift_r[WORD_BITS-1])) else $error("bad msb");
  AST_SUPPLY: assert property (@(posedge clk_sys)
    !supplyLowN |-> cmd_r == '0) else $error("command kept in supply reset");
  // direct input of channel six must drive its gate as well
  AST_PWM6: assert property (@(posedge clk_sys) disable iff (devRst)
    (en_q && pwm6_q) |-> gateDrive[`OSS_CH6_BIT]) else $error("direct six ignored");
  // the output enable must follow select fall within one cycle
  AST_OEON: assert property (@(posedge clk_sys) disable iff (devRst)
    (clkEn && csFall) |=> doutOe_r) else $error("serial output not enabled");
  // no channel may be driven while the supply monitor is low
  AST_RSTOFF: assert property (@(posedge clk_sys)
    !supplyLowN |-> gateDrive == '0) else $error("drive in supply reset");
  // status is loaded as zero while detection is off
  AST_NOREPORT: assert property (@(posedge clk_sys) disable iff (devRst)
    (clkEn && csFall && !en_q) |=> shift_r == '0) else $error("report while disabled");

  // main scenarios: latch, load then shift, enable return, pwm override

  COV_LATCH: cover property (@(posedge clk_sys) disable iff (devRst) csRise);
  COV_LOAD: cover property (@(posedge clk_sys) disable iff (devRst) csFall ##[1:50] sclkRise);
  COV_ENRET: cover property (@(posedge clk_sys) disable iff (devRst) !en_q ##1 en_q);
  COV_PWM: cover property (@(posedge clk_sys) disable iff (devRst) en_q && pwm5_q && pwm6_q);
endmodule
`default_nettype wire

//--- oss_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the link; every pin moves on a falling clk_sys edge
module oss_host_model
  import oss_pkg::*;
(
  input wire logic clk_sys,
  output oss_link_s link,
  input wire oss_dout_s pin
);
  // select high and clock parked low between frames
  initial link = '{1'b1, 1'b0, 1'b0};
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one frame of n bits, msb first; 40 ns clock half periods
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    link.csN = 1'b0;
    hold(8);
    for (int i = n - 1; i >= 0; i--) begin
      link.sdi = w[i];
      link.sclk = 1'b1;
      hold(4);
      link.sclk = 1'b0;
      hold(4);
      // bit launched by the last rise has settled by now
      r = {r[14:0], pin.dout};
    end
    // released data line shows the inverse, not a stale value
    link.sdi = ~link.sdi;
    link.csN = 1'b1;
    hold(8);
  endtask
endmodule
`default_nettype wire

//--- test_octal_switch_serial_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_octal_switch_serial_control;
  import oss_pkg::*;
  logic clk_sys = 0, rst = 1, supplyLowN = 1, cpEn = 1, pwm5 = 0, pwm6 = 0, faultEn;
  oss_word_t fault = '0, gate;
  oss_link_s link;
  oss_dout_s dout;
  int err_total = 0, checked = 0, seed = 92, cyc = 0, cmdM = 0;
  logic [15:0] rd, w;
  initial forever #5 clk_sys = ~clk_sys;
  oss_serial_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .clkEn(1'b1), .supplyLowN(supplyLowN),
    .linkIn(link), .chargePumpEn(cpEn), .direct_pwm_in_five(pwm5), .direct_pwm_in_six(pwm6),
    .chanFault(fault), .doutPin(dout), .gateDrive(gate), .faultSenseEn(faultEn));
  oss_host_model u_host (.clk_sys(clk_sys), .link(link), .pin(dout));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // model of the channel drive: command ORed with direct inputs, gated by enable
  function automatic logic [7:0] gExp();
    return cpEn ? (8'(cmdM) | {2'h0, pwm6, pwm5, 4'h0}) : 8'h00;
  endfunction
  task automatic finish_test();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, well above the six frames
  always @(posedge clk_sys) if (++cyc > 20000) begin
    err_total++;
    finish_test();
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    rst = 0;
    repeat (4) @(negedge clk_sys);
    chk("oe idle", 0, dout.doutOe);
    for (int k = 0; k < 6; k++) begin
      fault = 8'($random(seed));
      w = 16'($random(seed));
      // direct inputs change once only, far below the pwm ceiling
      if (k == 3) {pwm6, pwm5} = 2'b11;
      if (pwm5) w = w & 16'hffcf;
      u_host.xfer(w, (k == 5) ? 16 : 8, rd);
      // fault inputs are settled levels here, so no filter spacing is needed
      // host reads status as one bit per channel; class follows prior command
      if (k == 5) chk("chain", {fault, w[15:8]}, rd);
      else chk("status", 16'(fault), rd);
      cmdM = w[7:0];
      chk("gate", 16'(gExp()), 16'(gate));
      chk("oe off", 0, dout.doutOe);
      cpEn = 0;
      repeat (8) @(negedge clk_sys);
      chk("gate off", 0, {faultEn, gate});
      cpEn = 1;
      repeat (8) @(negedge clk_sys);
      chk("gate back", {7'h0, 1'b1, gExp()}, {faultEn, gate});
    end
    supplyLowN = 0;
    @(negedge clk_sys);
    chk("supply low", 0, gate);
    finish_test();
  end
endmodule
`default_nettype wire
